// [hdl/serial_unit.sv]
// serial unit: clocked synchronous and multiprocessor async engine with avalon slave
`timescale 1ns/1ps
module serial_unit
  import serial_unit_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  // clock and reset
  input logic mclk,
  input logic rstn,
  // avalon-mm slave
  input logic [4:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial line
  output logic txd_out,
  input logic rxd_in,
  // shift clock pin, three-signal form
  input logic shift_clock_pin_in,
  output logic shift_clock_pin_out,
  output logic shift_clock_pin_oe,
  // interrupt requests
  output logic tx_empty_irq,
  output logic tx_done_irq,
  output logic rx_full_irq,
  output logic rx_fault_irq
);
  // register decode shared by every write strobe
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    return a == ofs;
  endfunction

  mode_t mode_q;               // serial_mode_reg
  ctrl_t ctrl_q;               // serial_control_reg
  logic [7:0] tx_holding_reg;  // pending transmit character
  logic [7:0] rx_holding_reg;  // last accepted character
  logic [BAUD_W-1:0] baud_q;   // divider reload value
  logic tx_holding_empty;
  logic tx_done_flag;
  logic rx_holding_full;
  logic overrun_flag;
  logic framing_fault_flag;
  logic parity_fault_flag;
  logic rx_id_bit;
  logic tx_id_bit;
  logic ack_q;                 // second cycle of an access
  logic [31:0] rdata_q;
  logic [31:0] rmux;

  // bus handshake: every access takes exactly two cycles
  logic req;
  logic acc_wr;
  logic acc_rd;
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign acc_wr = avs_write & ack_q;
  assign acc_rd = avs_read & ack_q;
  assign avs_readdata = rdata_q;

  logic wr_mode;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_txd;
  logic rd_rxd;
  logic wr_baud;
  assign wr_mode = acc_wr & hit(avs_address, OFS_MODE) & avs_byteenable[0];
  assign wr_ctrl = acc_wr & hit(avs_address, OFS_CTRL) & avs_byteenable[0];
  assign wr_stat = acc_wr & hit(avs_address, OFS_STAT) & avs_byteenable[0];
  assign wr_txd = acc_wr & hit(avs_address, OFS_TXD) & avs_byteenable[0];
  assign rd_rxd = acc_rd & hit(avs_address, OFS_RXD);
  assign wr_baud = acc_wr & hit(avs_address, OFS_BAUD) & (&avs_byteenable[1:0]);

  logic [7:0] stat;
  assign stat = {tx_holding_empty, rx_holding_full, overrun_flag, framing_fault_flag,
                 parity_fault_flag, tx_done_flag, rx_id_bit, tx_id_bit};

  // ack toggles so back-to-back requests still see a wait cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ack_q <= 1'b0;
    else ack_q <= req & ~ack_q;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (avs_address)
      OFS_MODE: rmux[3:0] = mode_q;
      OFS_CTRL: rmux[7:0] = ctrl_q;
      OFS_STAT: rmux[7:0] = stat;
      OFS_TXD: rmux[7:0] = tx_holding_reg;
      OFS_RXD: rmux[7:0] = rx_holding_reg;
      OFS_BAUD: rmux[BAUD_W-1:0] = baud_q;
      default: rmux = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, stable at the ack edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata_q <= 32'h0000_0000;
    else if (req & ~ack_q) rdata_q <= rmux;
  end

  // plain configuration registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
      baud_q <= BAUD_W'(BAUD_RST);
      tx_holding_reg <= 8'h00;
    end else begin
      if (wr_mode) mode_q <= avs_writedata[3:0];
      if (wr_baud) baud_q <= avs_writedata[BAUD_W-1:0];
      if (wr_txd) tx_holding_reg <= avs_writedata[7:0];
    end
  end

  // mode decode
  logic sync_m;     // clocked synchronous mode
  logic ext_clk;    // clock taken from pin
  logic mp_on;      // multiprocessor async format
  logic has_extra;  // async frame carries parity or id bit
  logic par_on;
  logic err_any;
  assign sync_m = mode_q.sync_async_select;
  assign ext_clk = ctrl_q.clock_source_sel_hi;
  assign mp_on = ~sync_m & mode_q.mp_format;
  assign par_on = ~sync_m & mode_q.parity_en & ~mode_q.mp_format;
  // sync frames get no extra bit
  assign has_extra = mp_on | par_on;
  assign err_any = overrun_flag | framing_fault_flag | parity_fault_flag;

  // baud divider, free running
  logic [BAUD_W-1:0] div_cnt_q;
  logic tick;
  assign tick = div_cnt_q >= baud_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) div_cnt_q <= '0;
    else if (tick) div_cnt_q <= '0;
    else div_cnt_q <= div_cnt_q + 1'b1;
  end

  // pin clock and receive data synchronised
  logic sck_s;
  logic rxd_s;
  logic sck_d_q;
  sync2 #(.W(2)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din({shift_clock_pin_in, rxd_in}),
    .dout({sck_s, rxd_s})
  );
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) sck_d_q <= 1'b1;
    else sck_d_q <= sck_s;
  end

  // internal shift clock: toggles while a path runs, parks high
  logic sck_q;
  logic run;
  logic int_sync;
  logic tx_busy_q;
  logic rx_run;
  assign int_sync = sync_m & ~ext_clk;
  assign run = tx_busy_q | rx_run;
  // pulses only while active, idle high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) sck_q <= 1'b1;
    else if (!int_sync) sck_q <= 1'b1;
    else if (tick & (run | ~sck_q)) sck_q <= ~sck_q;
  end
  // pin driven only when the unit owns the clock
  assign shift_clock_pin_out = sck_q;
  assign shift_clock_pin_oe = int_sync;

  // edge events from whichever source is selected
  clk_ev_t ev;
  assign ev.fall = sync_m & (ext_clk ? (~sck_s & sck_d_q) : (tick & sck_q & run));
  assign ev.rise = sync_m & (ext_clk ? (sck_s & ~sck_d_q) : (tick & ~sck_q));
  assign ev.tick16 = ~sync_m & (ext_clk ? (sck_s & ~sck_d_q) : tick);

  // transmit frame assembly: async bit 0 is the start bit
  logic [10:0] tx_word;
  logic tx_extra;
  logic [3:0] tx_len;
  assign tx_extra = mp_on ? tx_id_bit : (^tx_holding_reg ^ mode_q.parity_odd);
  assign tx_len = has_extra ? FRAME_LEN_EXT : FRAME_LEN_BASE;
  always_comb begin
    tx_word = {3'b000, tx_holding_reg};
    if (!sync_m) begin
      // id bit goes out as written
      tx_word = has_extra ? {1'b1, tx_extra, tx_holding_reg, 1'b0}
                          : {2'b11, tx_holding_reg, 1'b0};
    end
  end

  logic [10:0] tx_frame_q;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_phase_q;
  logic tx_last_q;  // sync: bit 7 out, waiting for final rise
  logic load_ok;
  logic tx_start;
  logic tx_bound;
  logic tx_load;
  logic tx_fin;
  assign load_ok = ctrl_q.tx_enable & ~tx_holding_empty & ~(sync_m & err_any);
  assign tx_start = ~tx_busy_q & load_ok;
  // decision point: sync bit 7 fall, async last phase of the final frame bit
  assign tx_bound = tx_busy_q & (sync_m ? (ev.fall & (tx_cnt_q == LAST_DATA_BIT))
      : (ev.tick16 & (tx_phase_q == LAST_PHASE) & (tx_cnt_q == tx_len - 4'h1)));
  assign tx_load = tx_start | (tx_bound & load_ok);
  assign tx_fin = tx_bound & ~load_ok;

  // transmit shifter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_busy_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_frame_q <= 11'h7ff;
      tx_cnt_q <= 4'h0;
      tx_phase_q <= 4'h0;
      txd_out <= 1'b1;
    end else if (!ctrl_q.tx_enable) begin
      // disable resets the transmitter, line idles high
      tx_busy_q <= 1'b0;
      tx_last_q <= 1'b0;
      txd_out <= 1'b1;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_frame_q <= tx_word;
      tx_cnt_q <= 4'h0;
      tx_phase_q <= 4'h0;
    end else if (tx_busy_q & sync_m) begin
      if (ev.fall & ~tx_last_q) begin
        txd_out <= tx_frame_q[tx_cnt_q];
        if (tx_load) begin
          tx_frame_q <= tx_word;
          tx_cnt_q <= 4'h0;
        end else if (tx_fin) begin
          tx_last_q <= 1'b1;
        end else begin
          tx_cnt_q <= tx_cnt_q + 4'h1;
        end
      end
      // stop after the eighth rise, txd keeps msb
      if (ev.rise & tx_last_q) begin
        tx_busy_q <= 1'b0;
        tx_last_q <= 1'b0;
      end
    end else if (tx_busy_q & ev.tick16) begin
      // async: bit driven at phase 0, sixteen ticks per bit
      if (tx_phase_q == 4'h0) txd_out <= tx_frame_q[tx_cnt_q];
      tx_phase_q <= tx_phase_q + 4'h1;
      if (tx_load) begin
        tx_frame_q <= tx_word;
        tx_cnt_q <= 4'h0;
      end else if (tx_fin) begin
        tx_busy_q <= 1'b0;
      end else if (tx_phase_q == LAST_PHASE) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
    end
  end

  // receive engine
  logic [7:0] rx_shift_reg;  // sync shift register
  logic [10:0] rx_frame_q;   // async frame, bit 0 = start
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_phase_q;
  logic rx_act_q;            // async frame in progress
  logic rx_done;             // character complete this cycle
  logic [7:0] rx_data;
  logic rx_extra;
  // halted while any error flag set
  assign rx_run = ctrl_q.rx_enable & ~err_any;
  assign rx_done = sync_m ? (ev.rise & rx_run & (rx_cnt_q == LAST_DATA_BIT))
      : (ev.tick16 & rx_act_q & (rx_phase_q == SAMPLE_PHASE)
         & (rx_cnt_q == tx_len - 4'h1));
  assign rx_data = sync_m ? {rxd_s, rx_shift_reg[7:1]} : rx_frame_q[8:1];
  assign rx_extra = rx_frame_q[9];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_shift_reg <= 8'h00;
      rx_frame_q <= 11'h000;
      rx_cnt_q <= 4'h0;
      rx_phase_q <= 4'h0;
      rx_act_q <= 1'b0;
    end else if (sync_m) begin
      rx_act_q <= 1'b0;
      if (!rx_run) begin
        rx_cnt_q <= 4'h0;
      end else if (ev.rise) begin
        rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
        rx_cnt_q <= (rx_cnt_q == LAST_DATA_BIT) ? 4'h0 : rx_cnt_q + 4'h1;
      end
    end else if (!rx_act_q) begin
      // wait for a start edge
      if (rx_run & ~rxd_s) begin
        rx_act_q <= 1'b1;
        rx_cnt_q <= 4'h0;
        rx_phase_q <= 4'h0;
      end
    end else if (ev.tick16) begin
      rx_phase_q <= rx_phase_q + 4'h1;
      if (rx_phase_q == SAMPLE_PHASE) begin
        rx_frame_q[rx_cnt_q] <= rxd_s;
        if (((rx_cnt_q == 4'h0) & rxd_s) | rx_done) rx_act_q <= 1'b0;
        else rx_cnt_q <= rx_cnt_q + 4'h1;
      end
    end
  end

  // receive decode
  logic pe;
  logic fe;
  logic skip;
  logic id_hit;
  assign pe = par_on & (^{rx_data, rx_extra} ^ mode_q.parity_odd);
  assign fe = ~sync_m & ~rxd_s;
  // extra bit one marks an id frame
  assign skip = mp_on & ctrl_q.id_wait_enable & ~rx_extra;
  assign id_hit = rx_done & mp_on & ctrl_q.id_wait_enable & rx_extra;

  // control register; hardware auto-clear of id wait wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= avs_writedata[7:0];
      if (id_hit) ctrl_q.id_wait_enable <= 1'b0;
    end
  end

  // transmit flags; hardware set placed last so it beats a clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_holding_empty <= 1'b1;
      tx_done_flag <= 1'b1;
      tx_id_bit <= 1'b0;
    end else begin
      if (wr_stat) tx_id_bit <= avs_writedata[ST_TX_ID];
      if (wr_txd) tx_holding_empty <= 1'b0;
      if (tx_start) tx_done_flag <= 1'b0;
      if (tx_load) tx_holding_empty <= 1'b1;
      if (!ctrl_q.tx_enable) tx_holding_empty <= 1'b1;
      if (tx_fin) tx_done_flag <= 1'b1;
    end
  end

  // receive flags and holding register; rx disable touches none of them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_holding_reg <= 8'h00;
      rx_holding_full <= 1'b0;
      overrun_flag <= 1'b0;
      framing_fault_flag <= 1'b0;
      parity_fault_flag <= 1'b0;
      rx_id_bit <= 1'b0;
    end else begin
      // only software clears errors, by writing zero
      if (wr_stat) begin
        if (!avs_writedata[ST_OVR]) overrun_flag <= 1'b0;
        if (!avs_writedata[ST_FRM]) framing_fault_flag <= 1'b0;
        if (!avs_writedata[ST_PAR]) parity_fault_flag <= 1'b0;
        if (!avs_writedata[ST_FULL]) rx_holding_full <= 1'b0;
      end
      if (rd_rxd) rx_holding_full <= 1'b0;
      if (rx_done & ~skip) begin
        if (mp_on) rx_id_bit <= rx_extra;
        if (fe) framing_fault_flag <= 1'b1;
        if (pe) parity_fault_flag <= 1'b1;
        if (rx_holding_full) begin
          overrun_flag <= 1'b1;
        end else begin
          rx_holding_reg <= rx_data;
          if (!(fe | pe)) rx_holding_full <= 1'b1;
        end
      end
    end
  end

  // requests are flag and enable levels
  assign tx_empty_irq = tx_holding_empty & ctrl_q.tx_empty_irq_en;
  assign tx_done_irq = tx_done_flag & ctrl_q.tx_done_irq_en;
  assign rx_full_irq = rx_holding_full & ctrl_q.rx_irq_en;
  assign rx_fault_irq = err_any & ctrl_q.rx_irq_en;
endmodule

// [hdl/serial_unit_pkg.sv]
// constants, field layouts and carriers shared by the serial unit
package serial_unit_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_TXD = 5'h0c;
  localparam logic [4:0] OFS_RXD = 5'h10;
  localparam logic [4:0] OFS_BAUD = 5'h14;
  // serial_mode_reg layout, bit 3 downward
  typedef struct packed {
    logic mp_format;         // bit 3: multiprocessor frame
    logic parity_odd;        // bit 2: odd parity
    logic parity_en;         // bit 1: parity bit added
    logic sync_async_select; // bit 0: 1 = clocked synchronous
  } mode_t;
  // serial_control_reg layout, bit 7 downward
  typedef struct packed {
    logic tx_empty_irq_en;     // bit 7
    logic rx_irq_en;           // bit 6
    logic tx_enable;           // bit 5
    logic rx_enable;           // bit 4
    logic tx_done_irq_en;      // bit 3
    logic id_wait_enable;      // bit 2
    logic clock_source_sel_hi; // bit 1: 1 = external clock on pin
    logic clock_source_sel_lo; // bit 0
  } ctrl_t;
  // shift clock events seen by both paths
  typedef struct packed {
    logic fall;   // sync: shift-out edge
    logic rise;   // sync: sample edge
    logic tick16; // async: 16x basic clock
  } clk_ev_t;
  // serial_status_reg bit positions
  localparam int ST_TX_ID = 0;
  localparam int ST_RX_ID = 1;
  localparam int ST_DONE = 2;
  localparam int ST_PAR = 3;
  localparam int ST_FRM = 4;
  localparam int ST_OVR = 5;
  localparam int ST_FULL = 6;
  localparam int ST_EMPTY = 7;
  // reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0003;
  // character and frame timing counts
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] LAST_PHASE = 4'hf;
  localparam logic [3:0] FRAME_LEN_BASE = 4'ha;
  localparam logic [3:0] FRAME_LEN_EXT = 4'hb;
endpackage

// [hdl/sync2.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input logic mclk,
  input logic rstn,
  // raw and synchronised levels
  input logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q; // first stage, read only by the second

  // idle lines are high, so both stages reset high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '1;
      dout <= '1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// [sim/serial_unit_asserts.sv]
// port-level concurrent checks for the serial unit
`timescale 1ns/1ps
module serial_unit_asserts
  import serial_unit_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // serial line and clock pin
  input wire logic txd_out,
  input wire logic rxd_in,
  input wire logic shift_clock_pin_in,
  input wire logic shift_clock_pin_out,
  input wire logic shift_clock_pin_oe,
  // interrupt requests
  input wire logic tx_empty_irq,
  input wire logic tx_done_irq,
  input wire logic rx_full_irq,
  input wire logic rx_fault_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // access accepted in this cycle
  wire acc = (avs_read | avs_write) & ~avs_waitrequest;

  AST_ONE_WAIT:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access held more than one wait cycle");
  AST_NO_REQ_NO_WAIT:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised without a request");
  AST_RD_UPPER_ZERO:
    assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_SCK_PULSE_SHORT:
    assert property ($fell(shift_clock_pin_out) && shift_clock_pin_oe
      |-> ##[1:16] shift_clock_pin_out)
    else $error("shift clock stuck low");
  AST_TXD_AFTER_FALL:
    assert property ($changed(txd_out) && shift_clock_pin_oe
      |-> $past(shift_clock_pin_out) && !shift_clock_pin_out)
    else $error("serial output moved away from a falling clock edge");
  AST_OVR_KEEPS_FULL:
    assert property ($rose(rx_fault_irq) |-> rx_full_irq)
    else $error("overrun without full flag kept");
  AST_RX_READ_CLEARS:
    assert property (acc && avs_read && avs_address == OFS_RXD && !rx_fault_irq
      |=> !rx_full_irq)
    else $error("receive read left full flag set");
  AST_TX_WRITE_CLEARS:
    assert property (acc && avs_write && avs_address == OFS_TXD && avs_byteenable[0]
      |=> !tx_empty_irq)
    else $error("transmit write left empty flag set");
  AST_DONE_CLOCK_IDLE:
    assert property ($rose(tx_done_irq) && shift_clock_pin_oe
      |-> ##[0:16] shift_clock_pin_out ##1 shift_clock_pin_out [*8])
    else $error("clock pin not held high after transmit end");
  // main scenarios reached
  cover property ($rose(rx_full_irq));
  cover property ($rose(rx_fault_irq));
  cover property ($rose(tx_done_irq));
endmodule

// [sim/serial_peer.sv]
// serial peer sharing the unit's shift clock
`timescale 1ns/1ps
module serial_peer (
  // reset and shared clock line
  input wire logic rstn,
  input wire logic sck,
  // data both ways
  input wire logic txd,
  output logic rxd,
  // stimulus and capture
  input wire logic loop,
  input wire logic [7:0] send_byte,
  output logic [7:0] got_byte,
  output logic [7:0] got_cnt,
  output logic [7:0] rise_cnt
);
  logic [7:0] sh_in; // captured bits
  logic [7:0] sh_out; // character in flight
  logic [2:0] ibit, obit; // bit positions
  logic drv; // driven level
  initial begin
    sh_in = 8'h00;
    sh_out = 8'hff;
    ibit = 3'd0;
    obit = 3'd0;
    drv = 1'b1;
    got_byte = 8'h00;
    got_cnt = 8'h00;
    rise_cnt = 8'h00;
  end
  // lsb first capture on rise, edges during reset ignored
  always @(posedge sck) begin
    if (rstn === 1'b1) begin
      sh_in = {txd, sh_in[7:1]};
      rise_cnt = rise_cnt + 8'd1;
      if (ibit == 3'd7) begin
        got_byte = sh_in;
        got_cnt = got_cnt + 8'd1;
      end
      ibit = ibit + 3'd1;
    end
  end
  // next bit on each fall, new character every eight
  always @(negedge sck) begin
    if (rstn === 1'b1) begin
      if (obit == 3'd0) sh_out = send_byte;
      drv = sh_out[obit];
      obit = obit + 3'd1;
    end
  end
  // loop mode returns the unit's own async frames
  assign rxd = loop ? txd : drv;
endmodule

// [sim/test_serial_unit.sv]
// self-checking bench for the serial unit
`timescale 1ns/1ps
module test_serial_unit;
  import serial_unit_pkg::*;
  // design ports
  logic mclk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic txd_out, rxd_in, pin_out, pin_oe;
  logic tx_empty_irq, tx_done_irq, rx_full_irq, rx_fault_irq;
  // peer side
  logic loop;
  logic ext_sck; // bench-made clock for the released pin, idle high
  logic [7:0] send_byte, got_byte, got_cnt, rise_cnt;
  int mismatches, tests_run;
  // released clock pin follows the bench's external clock
  wire sck_line = pin_oe ? pin_out : ext_sck;

  serial_unit dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd_out(txd_out),
    .rxd_in(rxd_in), .shift_clock_pin_in(sck_line), .shift_clock_pin_out(pin_out),
    .shift_clock_pin_oe(pin_oe), .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
    .rx_full_irq(rx_full_irq), .rx_fault_irq(rx_fault_irq));
  serial_peer peer (.rstn(rstn), .sck(sck_line), .txd(txd_out), .rxd(rxd_in), .loop(loop),
    .send_byte(send_byte), .got_byte(got_byte), .got_cnt(got_cnt), .rise_cnt(rise_cnt));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd,
    output logic [7:0] rd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    bus(1'b0, a, 8'h00, d);
  endtask
  // poll until the transmitter reports its end
  task automatic wait_done;
    logic [7:0] d;
    repeat (4) @(posedge mclk);
    do rd(OFS_STAT, d); while (d[ST_DONE] !== 1'b1);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    rd(OFS_STAT, d); chk("stat_rst", d, 8'h84);
    wr(OFS_STAT, 8'hff);
    rd(OFS_STAT, d); chk("stat_w1", d, 8'h85);
    wr(OFS_STAT, 8'h00);
    rd(OFS_CTRL, d); chk("ctrl_rst", d, 8'h00);
    rd(OFS_BAUD, d); chk("baud_rst", d, 8'h03);
    rd(5'h18, d); chk("unmapped", d, 8'h00);
    chk("irq_rst", {4'h0, tx_empty_irq, tx_done_irq, rx_full_irq, rx_fault_irq}, 8'h00);
  endtask
  // sync mode with parity and id options set, which must not show
  task automatic t_tx_one;
    logic [7:0] r0;
    wr(OFS_MODE, 8'h0f);
    wr(OFS_CTRL, 8'ha8);
    // keep the clock idle a while after the done request rises
    repeat (12) @(posedge mclk);
    chk("done_irq_idle", {7'h0, tx_done_irq}, 8'h01);
    chk("pin_driven", {7'h0, pin_oe}, 8'h01);
    r0 = rise_cnt;
    wr(OFS_TXD, 8'h25);
    repeat (3) @(posedge mclk);
    chk("empty_irq", {7'h0, tx_empty_irq}, 8'h01);
    chk("done_irq_busy", {7'h0, tx_done_irq}, 8'h00);
    while (got_cnt !== 8'd1) @(posedge mclk);
    repeat (16) @(posedge mclk);
    chk("tx_byte", got_byte, 8'h25);
    chk("pulses", rise_cnt - r0, 8'd8);
    chk("txd_hold", {7'h0, txd_out}, 8'h00);
    chk("sck_idle", {7'h0, sck_line}, 8'h01);
    chk("done_irq_end", {7'h0, tx_done_irq}, 8'h01);
  endtask
  // second character queued during the first: 64 cycles per character at divisor 3
  task automatic t_tx_chain;
    logic [7:0] d;
    int n;
    wr(OFS_TXD, 8'h3c);
    do rd(OFS_STAT, d); while (d[ST_EMPTY] !== 1'b1);
    wr(OFS_TXD, 8'hc3);
    while (got_cnt !== 8'd2) @(posedge mclk);
    chk("chain_a", got_byte, 8'h3c);
    n = 0;
    while (got_cnt !== 8'd3) begin
      @(posedge mclk);
      n++;
    end
    chk("chain_b", got_byte, 8'hc3);
    chk("chain_gap", n[7:0], 8'd64);
  endtask
  task automatic t_rx;
    logic [7:0] d, r0;
    send_byte <= 8'h5a;
    wr(OFS_CTRL, 8'h00);
    // both enables set in one write
    wr(OFS_CTRL, 8'h70);
    while (rx_full_irq !== 1'b1) @(posedge mclk);
    // next character chosen well before the peer's next fall
    send_byte <= 8'h0f;
    rd(OFS_RXD, d);
    chk("rx_byte", d, 8'h5a);
    @(posedge mclk);
    chk("full_clr", {7'h0, rx_full_irq}, 8'h00);
    // third character differs, so a lost one would show
    while (rx_full_irq !== 1'b1) @(posedge mclk);
    send_byte <= 8'hf0;
    while (rx_fault_irq !== 1'b1) @(posedge mclk);
    rd(OFS_STAT, d); chk("ovr_full", d & 8'h60, 8'h60);
    r0 = rise_cnt;
    wr(OFS_TXD, 8'h99);
    repeat (100) @(posedge mclk);
    rd(OFS_STAT, d); chk("tx_blocked", d & 8'h80, 8'h00);
    chk("rx_halt", rise_cnt - r0, 8'h00);
    wr(OFS_CTRL, 8'h40);
    rd(OFS_STAT, d); chk("disable_keeps", d & 8'he0, 8'he0);
    rd(OFS_RXD, d); chk("rx_kept", d, 8'h0f);
    wr(OFS_STAT, 8'h00);
  endtask
  // external clock on the pin: bench makes eight slow pulses
  task automatic t_ext;
    logic [7:0] d;
    wr(OFS_CTRL, 8'h22);
    wr(OFS_TXD, 8'h96);
    repeat (4) @(posedge mclk);
    chk("pin_released", {7'h0, pin_oe}, 8'h00);
    repeat (8) begin
      ext_sck <= 1'b0;
      repeat (8) @(posedge mclk);
      ext_sck <= 1'b1;
      repeat (8) @(posedge mclk);
    end
    chk("ext_byte", got_byte, 8'h96);
    rd(OFS_STAT, d); chk("ext_done", d & 8'h84, 8'h84);
  endtask
  // multiprocessor frames looped back, parity enable set but ignored
  task automatic t_mp;
    logic [7:0] d;
    loop <= 1'b1;
    wr(OFS_MODE, 8'h0a);
    wr(OFS_CTRL, 8'h74);
    // data frame sent with id bit zero
    wr(OFS_STAT, 8'h00);
    wr(OFS_TXD, 8'h11);
    wait_done;
    chk("skip_data", {7'h0, rx_full_irq}, 8'h00);
    wr(OFS_STAT, 8'h01);
    wr(OFS_TXD, 8'h22);
    wait_done;
    chk("id_irq", {7'h0, rx_full_irq}, 8'h01);
    rd(OFS_STAT, d); chk("id_flags", d & 8'h5a, 8'h42);
    rd(OFS_CTRL, d); chk("wait_off", d, 8'h70);
    rd(OFS_RXD, d); chk("id_data", d, 8'h22);
  endtask

  task automatic stop_test;
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // 40 mhz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // watchdog well above the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test;
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    loop = 1'b0;
    ext_sck = 1'b1;
    send_byte = 8'h00;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_regs;
    t_tx_one;
    t_tx_chain;
    t_rx;
    t_ext;
    t_mp;
    stop_test;
  end
endmodule

bind serial_unit serial_unit_asserts u_chk (.mclk(mclk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd_out(txd_out),
  .rxd_in(rxd_in), .shift_clock_pin_in(shift_clock_pin_in),
  .shift_clock_pin_out(shift_clock_pin_out), .shift_clock_pin_oe(shift_clock_pin_oe),
  .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq), .rx_full_irq(rx_full_irq),
  .rx_fault_irq(rx_fault_irq));
